// [logic/tws_pkg.sv]
package tws_pkg;
    // wishbone word offsets (byte addresses)
    localparam logic [3:0] ADDR_DATA    = 4'h0;
    localparam logic [3:0] ADDR_CTRL    = 4'h4;
    localparam logic [3:0] ADDR_STATUS  = 4'h8;
    localparam logic [3:0] ADDR_OWN     = 4'hC;
    // control register fields
    localparam int CTRL_INT   = 7;
    localparam int CTRL_ACK   = 6;
    localparam int CTRL_STA   = 5;
    localparam int CTRL_STO   = 4;
    localparam int CTRL_EN    = 2;
    localparam int CTRL_SLEEP = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] OWN_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'hFF;
    // status codes, prescaler bits taken as zero
    localparam logic [7:0] ST_SLA_R   = 8'hA8;
    localparam logic [7:0] ST_ARB_R   = 8'hB0;
    localparam logic [7:0] ST_DATA_AK = 8'hB8;
    localparam logic [7:0] ST_DATA_NK = 8'hC0;
    localparam logic [7:0] ST_LAST_AK = 8'hC8;
    localparam logic [7:0] ST_IDLE    = 8'hF8;
    localparam logic [7:0] ST_BUS_ERR = 8'h00;
    localparam logic [7:0] ST_PRE_MASK = 8'hF8;
    localparam logic [6:0] GEN_CALL   = 7'h00;
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] BIT_TOP = 3'h7;
    typedef enum logic [2:0] {
        TWS_IDLE, TWS_ADDR, TWS_AACK, TWS_SEND, TWS_MACK, TWS_IGNORE
    } tws_state_e;
endpackage

// [logic/tws_slave_tx.sv]
`timescale 1ns/1ps
// What this block does
// - status codes are defined with prescaler bits zero
// - respond only when address matches own_address_field bits 7:1
// - general call answered only when own register bit 0 is one or own register bits 7:1 are all zero
// - read bit selects slave transmit; a write bit is not acked and the frame is ignored
// - after address and direction acked, set flag with valid status
// - status A8: own address read acked; load byte, ack-enable picks last
// - arbitration lost then addressed for read: ack, status B0
// - status B8: byte sent and acked; load next byte
// - C0: nack received; clearing flag returns to unaddressed slave
// - C8: last byte acked by master; same unaddressed choices
// - clearing ack-enable mid transfer makes current byte the last
// - after last byte ignore master, leave SDA released
// - ack-enable zero: ignore own address, keep watching the bus
// - in deep sleep still ack own or general address and wake
// - after wake hold SCL low until software clears the flag
// - data register content undefined after wake
// - status reads F8 when flag is clear
// - misplaced start/stop gives status 00; stop bit plus clear recovers
module tws_slave_tx (
    input  wire logic        clk_i,      // 40 MHz system clock
    input  wire logic        rst_n_i,    // async reset, active low
    input  wire logic        ce_i,       // clock enable
    input  wire logic        wb_cyc_i,   // wishbone cycle
    input  wire logic        wb_stb_i,   // wishbone strobe
    input  wire logic        wb_we_i,    // wishbone write
    input  wire logic [3:0]  wb_adr_i,   // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,   // wishbone byte selects
    input  wire logic [31:0] wb_dat_i,   // wishbone write data
    output logic      [31:0] wb_dat_o,   // wishbone read data
    output logic             wb_ack_o,   // wishbone acknowledge
    input  wire logic        arb_lost_i, // own master lost in address
    input  wire logic        scl_i,      // scl pin level
    output logic             scl_o,      // scl drive value (low)
    output logic             scl_oe_o,   // scl driven low when high
    input  wire logic        sda_i,      // sda pin level
    output logic             sda_o,      // sda drive value (low)
    output logic             sda_oe_o,   // sda driven low when high
    output logic             wake_o,     // wake request to system
    output logic             start_pend_o // start queued for free bus
);
    logic scl_s, scl_d, sda_s, sda_d;
    tws_sync u_scl (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
                    .d_i(scl_i), .q_o(scl_s), .q_d_o(scl_d));
    tws_sync u_sda (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
                    .d_i(sda_i), .q_o(sda_s), .q_d_o(sda_d));

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

    tws_pkg::tws_state_e state, next_state;
    logic [7:0] ctrl, next_ctrl;
    logic [7:0] own, next_own;
    logic [7:0] data, next_data;
    logic [7:0] status, next_status;
    logic [7:0] shreg, next_shreg;
    logic [2:0] bitn, next_bitn;
    logic       last, next_last;
    logic       sda_drv, next_sda_drv;
    logic       scl_hold, next_scl_hold;
    logic       woke, next_woke;
    logic       ack, next_ack;
    logic [31:0] rdat, next_rdat;
    logic       start_pend, next_start_pend;

    wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    wire rd_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire flag = ctrl[tws_pkg::CTRL_INT];
    wire clr_flag = wr && wb_adr_i == tws_pkg::ADDR_CTRL
                    && wb_dat_i[tws_pkg::CTRL_INT];
    // address hit: top 7 shifted bits match own bits 7:1, or general call with own bit 0 set
    wire addr_hit = (shreg[7:1] == own[7:1]) ||
                    (own[0] && shreg[7:1] == tws_pkg::GEN_CALL);
    wire in_frame = state != tws_pkg::TWS_IDLE
                    && state != tws_pkg::TWS_IGNORE;

    always_comb begin
        next_state      = state;
        next_ctrl       = ctrl;
        next_own        = own;
        next_data       = data;
        next_status     = status;
        next_shreg      = shreg;
        next_bitn       = bitn;
        next_last       = last;
        next_sda_drv    = sda_drv;
        next_scl_hold   = scl_hold;
        next_woke       = woke;
        next_start_pend = start_pend;
        next_ack        = rd_req;
        next_rdat       = 32'h0000_0000;
        // software side; set from hardware below wins over this clear
        if (wr) begin
            case (wb_adr_i)
                tws_pkg::ADDR_DATA: next_data = wb_dat_i[7:0];
                tws_pkg::ADDR_OWN:  next_own  = wb_dat_i[7:0];
                tws_pkg::ADDR_CTRL: begin
                    next_ctrl = wb_dat_i[7:0];
                    // writing one clears the flag, writing zero keeps it
                    next_ctrl[tws_pkg::CTRL_INT] = flag
                        & ~wb_dat_i[tws_pkg::CTRL_INT];
                end
                default: ;
            endcase
        end
        if (clr_flag) begin
            next_scl_hold = 1'b0;
            next_woke     = 1'b0;
            if (wb_dat_i[tws_pkg::CTRL_STO]
                && status == tws_pkg::ST_BUS_ERR) begin
                // recover without a stop on the bus
                next_ctrl[tws_pkg::CTRL_STO] = 1'b0;
                next_state   = tws_pkg::TWS_IDLE;
                next_sda_drv = 1'b0;
            end else if (status == tws_pkg::ST_DATA_NK
                      || status == tws_pkg::ST_LAST_AK) begin
                next_state   = tws_pkg::TWS_IDLE;
                next_sda_drv = 1'b0;
                next_start_pend = wb_dat_i[tws_pkg::CTRL_STA];
            end else if (status == tws_pkg::ST_SLA_R
                      || status == tws_pkg::ST_ARB_R
                      || status == tws_pkg::ST_DATA_AK) begin
                // ack-enable at clear decides whether this byte is last
                next_last  = ~wb_dat_i[tws_pkg::CTRL_ACK];
                next_shreg = data;
                // first bit goes out with the scl release, so that sda
                // never moves while scl is already high
                next_sda_drv = ~data[tws_pkg::BIT_TOP];
            end
        end
        if (ctrl[tws_pkg::CTRL_EN] && !scl_hold) begin
            if (in_frame && (start_c || stop_c)
                && state != tws_pkg::TWS_ADDR) begin
                next_ctrl[tws_pkg::CTRL_INT] = 1'b1;
                next_status   = tws_pkg::ST_BUS_ERR;
                next_scl_hold = 1'b1;
                next_sda_drv  = 1'b0;
            end else if (start_c) begin
                next_state = tws_pkg::TWS_ADDR;
                next_bitn  = 3'h0;
            end else if (stop_c) begin
                next_state = tws_pkg::TWS_IDLE;
                if (start_pend) next_start_pend = 1'b0;
            end else begin
                case (state)
                    tws_pkg::TWS_ADDR: if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_bitn  = bitn + 3'h1;
                        if (bitn == tws_pkg::BIT_TOP)
                            next_state = tws_pkg::TWS_AACK;
                    end
                    tws_pkg::TWS_AACK: if (scl_fall) begin
                        if (sda_drv) begin
                            // acked address; flag and stretch
                            next_sda_drv  = 1'b0;
                            next_ctrl[tws_pkg::CTRL_INT] = 1'b1;
                            next_status = arb_lost_i ? tws_pkg::ST_ARB_R
                                          : tws_pkg::ST_SLA_R;
                            next_scl_hold = 1'b1;
                            next_woke = ctrl[tws_pkg::CTRL_SLEEP];
                            next_bitn = 3'h0;
                            next_state = tws_pkg::TWS_SEND;
                        end else if (addr_hit && shreg[0]
                            && ctrl[tws_pkg::CTRL_ACK]) begin
                            next_sda_drv = 1'b1;
                        end else begin
                            next_state = tws_pkg::TWS_IGNORE;
                        end
                    end
                    tws_pkg::TWS_SEND: if (!flag) begin
                        if (!scl_s)
                            next_sda_drv = ~shreg[tws_pkg::BIT_TOP - bitn];
                        if (scl_fall) begin
                            if (bitn == tws_pkg::BIT_TOP) begin
                                next_state   = tws_pkg::TWS_MACK;
                                next_sda_drv = 1'b0;
                            end
                            next_bitn = bitn + 3'h1;
                        end
                    end
                    tws_pkg::TWS_MACK: if (scl_rise) begin
                        next_ctrl[tws_pkg::CTRL_INT] = 1'b1;
                        next_scl_hold = 1'b1;
                        if (sda_s) next_status = tws_pkg::ST_DATA_NK;
                        else if (last) next_status = tws_pkg::ST_LAST_AK;
                        else next_status = tws_pkg::ST_DATA_AK;
                        next_state = (sda_s || last) ? tws_pkg::TWS_IGNORE
                                     : tws_pkg::TWS_SEND;
                    end
                    tws_pkg::TWS_IGNORE: next_sda_drv = 1'b0;
                    default: next_state = tws_pkg::TWS_IDLE;
                endcase
            end
        end
        if (rd_req && !wb_we_i) begin
            case (wb_adr_i)
                // data register is not refreshed by a wake-up
                tws_pkg::ADDR_DATA:   next_rdat[7:0] = data;
                tws_pkg::ADDR_CTRL:   next_rdat[7:0] = ctrl;
                tws_pkg::ADDR_STATUS: next_rdat[7:0] = flag
                    ? (status & tws_pkg::ST_PRE_MASK)
                    : tws_pkg::ST_IDLE;
                tws_pkg::ADDR_OWN:    next_rdat[7:0] = own;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state      <= tws_pkg::TWS_IDLE;
            ctrl       <= tws_pkg::CTRL_RESET;
            own        <= tws_pkg::OWN_RESET;
            data       <= tws_pkg::DATA_RESET;
            status     <= tws_pkg::ST_IDLE;
            shreg      <= tws_pkg::DATA_RESET;
            bitn       <= 3'h0;
            last       <= 1'b0;
            sda_drv    <= 1'b0;
            scl_hold   <= 1'b0;
            woke       <= 1'b0;
            ack        <= 1'b0;
            rdat       <= 32'h0000_0000;
            start_pend <= 1'b0;
        end else if (ce_i) begin
            state      <= next_state;
            ctrl       <= next_ctrl;
            own        <= next_own;
            data       <= next_data;
            status     <= next_status;
            shreg      <= next_shreg;
            bitn       <= next_bitn;
            last       <= next_last;
            sda_drv    <= next_sda_drv;
            scl_hold   <= next_scl_hold;
            woke       <= next_woke;
            ack        <= next_ack;
            rdat       <= next_rdat;
            start_pend <= next_start_pend;
        end
    end

    assign wb_dat_o     = rdat;
    assign wb_ack_o     = ack;
    assign sda_o        = 1'b0;
    assign sda_oe_o     = sda_drv;
    assign scl_o        = 1'b0;
    assign scl_oe_o     = scl_hold;
    assign wake_o       = woke;
    assign start_pend_o = start_pend;

    a_hold_scl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && flag && $past(ce_i) && $past(flag) && !$past(clr_flag)
        |-> scl_oe_o) else $error("scl not stretched while flag set");
    a_status_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && wb_ack_o && !wb_we_i && wb_adr_i == tws_pkg::ADDR_STATUS
        && !$past(flag) |-> wb_dat_o[7:0] == tws_pkg::ST_IDLE)
        else $error("status not F8 with flag clear");
    a_ack_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_sla_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && $rose(flag) |-> status != tws_pkg::ST_IDLE)
        else $error("flag without valid status");
    a_noack_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && state == tws_pkg::TWS_AACK && scl_fall
        && !ctrl[tws_pkg::CTRL_ACK] && !sda_drv |=> !sda_drv)
        else $error("acked with ack-enable low");
    a_ignore_rel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && state == tws_pkg::TWS_IGNORE ##1 ce_i |-> !sda_oe_o)
        else $error("sda driven after last byte");
    a_bus_err: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && next_status == tws_pkg::ST_BUS_ERR && status != next_status
        |=> flag) else $error("bus error without flag");
    a_wake_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wake_o |-> flag || $past(clr_flag))
        else $error("wake without flag");
    c_read_addr: cover property (@(posedge clk_i)
        status == tws_pkg::ST_SLA_R && flag);
    c_nack: cover property (@(posedge clk_i)
        status == tws_pkg::ST_DATA_NK && flag);
    c_last_ack: cover property (@(posedge clk_i)
        status == tws_pkg::ST_LAST_AK && flag);
endmodule

// [logic/tws_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser plus one delayed copy for edge detection
module tws_sync (
    input  wire logic clk_i,   // system clock
    input  wire logic rst_n_i, // async reset
    input  wire logic ce_i,    // clock enable
    input  wire logic d_i,     // async level
    output logic      q_o,     // synchronised level
    output logic      q_d_o    // level one cycle earlier
);
    logic meta;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta  <= 1'b1;
            q_o   <= 1'b1;
            q_d_o <= 1'b1;
        end else if (ce_i) begin
            meta  <= d_i;
            q_o   <= meta;
            q_d_o <= q_o;
        end
    end
endmodule

// [tb/tws_master_model.sv]
`timescale 1ns/1ps
// bus master receiver; lines are open drain with pull-ups in the bench
module tws_master_model (
    input  wire logic scl_i,    // resolved scl line
    input  wire logic sda_i,    // resolved sda line
    output logic      scl_oe_o, // pull scl low when high
    output logic      sda_oe_o  // pull sda low when high
);
    logic [7:0] got [0:4];
    logic       addr_nack;

    initial begin
        scl_oe_o = 1'h0;
        sda_oe_o = 1'h0;
    end

    // low phase, release scl, sit out any stretching, sample mid high
    task automatic clk_bit(input logic b, output logic s);
        sda_oe_o = ~b;
        #100;
        scl_oe_o = 1'h0;
        wait (scl_i === 1'h1);
        #50 s = sda_i;
        #50 scl_oe_o = 1'h1;
        // sda moves 20 ns after scl is pulled low, before the synchroniser shows the fall
        #20;
    endtask

    task automatic read_tx(input logic [6:0] a, input int n,
                           input logic more, input logic abort);
        logic [7:0] sh;
        logic       s;
        int         i;
        int         j;
        sda_oe_o = 1'h0;
        scl_oe_o = 1'h0;
        #100 sda_oe_o = 1'h1;
        #100 scl_oe_o = 1'h1;
        #20 sh = {a, 1'h1};
        for (j = 7; j >= 0; j--) clk_bit(sh[j], s);
        clk_bit(1'h1, addr_nack);
        for (i = 0; i < n + more && addr_nack === 1'h0; i++) begin
            // an abort stops after three bits, mid byte
            for (j = 7; j >= (abort ? 5 : 0); j--) clk_bit(1'h1, sh[j]);
            if (abort) break;
            got[i] = sh;
            clk_bit(i >= n + more - 1, s);
        end
        sda_oe_o = 1'h1;
        #100 scl_oe_o = 1'h0;
        wait (scl_i === 1'h1);
        #100 sda_oe_o = 1'h0;
        #100;
    endtask
endmodule

// [tb/tws_slave_tx_tb.sv]
`timescale 1ns/1ps
module tws_slave_tx_tb;
    typedef struct packed {
        logic [7:0] own;
        logic [6:0] adr;
        logic [2:0] n;
        logic       more;
        logic       arb;
        logic       slp;
        logic       ae;
        logic       abort;
        logic [7:0] first;
    } tws_row_s;
    // first = F8 marks a row where the device must stay silent
    tws_row_s rows [10] = '{
        '{8'hA0, 7'h50, 3'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'hA8},
        '{8'hA0, 7'h50, 3'h3, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'hA8},
        '{8'hA0, 7'h50, 3'h2, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 8'hA8},
        '{8'hA0, 7'h51, 3'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'hF8},
        '{8'hA0, 7'h00, 3'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'hF8},
        '{8'hA1, 7'h00, 3'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'hA8},
        '{8'hA0, 7'h50, 3'h2, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 8'hB0},
        '{8'hA0, 7'h50, 3'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'hF8},
        '{8'hA0, 7'h50, 3'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 8'hA8},
        '{8'hA0, 7'h50, 3'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 8'hA8}};
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [31:0] dat;
    logic [31:0] rdat;
    logic        ack;
    logic        arb;
    logic        scl_oe;
    logic        sda_oe;
    logic        m_scl_oe;
    logic        m_sda_oe;
    logic        wake;
    logic [7:0]  q;
    int          failures = 0;
    int          n_checks = 0;
    wire logic   scl_line = ~(scl_oe | m_scl_oe);
    wire logic   sda_line = ~(sda_oe | m_sda_oe);

    tws_slave_tx tws_slave_tx_inst (.clk_i(clk), .rst_n_i(rst_n),
        .ce_i(1'h1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .arb_lost_i(arb), .scl_i(scl_line), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe),
        .wake_o(wake), .start_pend_o());
    tws_master_model tws_master_model_inst (.scl_i(scl_line),
        .sda_i(sda_line), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));

    always #12.5 clk = ~clk;

    task automatic stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle; waits for ack however long it takes
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] r);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we  <= w;
        adr <= a;
        dat <= {24'h0, d};
        // ack ends this wait; the watchdog catches an ack that never comes
        do @(posedge clk); while (ack !== 1'h1);
        r = rdat[7:0];
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk);
    endtask

    function automatic logic [7:0] dbyte(input int r, input int k);
        return {k[3:0], r[3:0]} ^ 8'h3C;
    endfunction

    task automatic serve(input tws_row_s rw, input int r);
        logic [7:0] st;
        logic [7:0] ex;
        int         k;
        int         p;
        if (rw.first == tws_pkg::ST_IDLE) return;
        for (k = 0; k <= rw.n; k++) begin
            ex = k == 0 ? rw.first : rw.abort ? tws_pkg::ST_BUS_ERR :
                 k < rw.n ? tws_pkg::ST_DATA_AK :
                 rw.more ? tws_pkg::ST_LAST_AK : tws_pkg::ST_DATA_NK;
            st = tws_pkg::ST_IDLE;
            for (p = 0; p < 3000 && st === tws_pkg::ST_IDLE; p++)
                wb(1'h0, tws_pkg::ADDR_STATUS, 8'h00, st);
            check({24'h0, st & tws_pkg::ST_PRE_MASK}, {24'h0, ex});
            if (k == 0) check({31'h0, scl_oe}, 32'h1);
            if (rw.slp && k == 0) check({31'h0, wake}, 32'h1);
            if (k < rw.n && !(rw.abort && k > 0)) begin
                wb(1'h1, tws_pkg::ADDR_DATA, dbyte(r, k), st);
                // clearing ack-enable marks the byte as the last
                ex = k == rw.n - 1 ? 8'h84 : 8'hC4;
                wb(1'h1, tws_pkg::ADDR_CTRL, ex, st);
            end else begin
                ex = rw.abort ? 8'hD4 : 8'hC4;
                wb(1'h1, tws_pkg::ADDR_CTRL, ex, st);
            end
            if (rw.slp && k == 0) check({31'h0, wake}, 32'h0);
        end
    endtask

    initial begin
        #1000000;
        failures++;
        $display("watchdog expired");
        stop_test;
    end

    initial begin
        logic [3:0] ra [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h1};
        logic [7:0] rv [5] = '{tws_pkg::DATA_RESET, tws_pkg::CTRL_RESET,
            tws_pkg::ST_IDLE, tws_pkg::OWN_RESET, 8'h00};
        int         r;
        int         k;
        clk = 1'h0;
        rst_n = 1'h0;
        cyc = 1'h0;
        stb = 1'h0;
        we = 1'h0;
        adr = 4'h0;
        dat = 32'h0;
        arb = 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        for (r = 0; r < 10; r++) begin
            wb(1'h1, tws_pkg::ADDR_OWN, rows[r].own, q);
            wb(1'h1, tws_pkg::ADDR_CTRL,
               {1'h0, rows[r].ae, 5'h02, rows[r].slp}, q);
            arb <= rows[r].arb;
            fork
                tws_master_model_inst.read_tx(rows[r].adr, rows[r].n,
                    rows[r].more, rows[r].abort);
                serve(rows[r], r);
            join
            arb <= 1'h0;
            check({31'h0, tws_master_model_inst.addr_nack},
                  {31'h0, rows[r].first == 8'hF8});
            for (k = 0; k < (rows[r].abort ? 0 : rows[r].n + rows[r].more)
                 && rows[r].first != 8'hF8; k++)
                check({24'h0, tws_master_model_inst.got[k]},
                      k < rows[r].n ? dbyte(r, k) : 32'hFF);
            wb(1'h0, tws_pkg::ADDR_STATUS, 8'h00, q);
            check({24'h0, q}, {24'h0, tws_pkg::ST_IDLE});
            check({30'h0, scl_oe, sda_oe}, 32'h0);
            $display("test %0d done", r);
        end
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        check({29'h0, scl_oe, sda_oe, wake}, 32'h0);
        for (k = 0; k < 5; k++) begin
            wb(1'h0, ra[k], 8'h00, q);
            check({24'h0, q}, {24'h0, rv[k]});
        end
        $display("test reset done");
        stop_test;
    end
endmodule
